// ### hw/wd_regs.svh
// Purpose: Register offsets, fields, reset values and timing counts of the
//          watchdog mode control block.
// Assumes: Byte-wide registers at their printed offsets.
// Notes:   Included by the package and the design modules.
//
// Functional notes
// R1: Config bits 5:4 pick undervoltage level 90/80/70/60 %; copied at start-up.
// R2: Config bit 3 enables forced normal, preset on; watchdog off there.
// R3: Config bit 2 enables the software development option, preset off.
// R4: Config bit 0 set marks sleep unsupported, preset supported.
// R5: Status bit 3 shows forced normal; bits 7:4 reserved.
// R6: Status bit 2 shows the development option active.
// R7: Status bits 1:0: 00 off, 01 first half, 10 second half.
// R8: Watchdog off in off, forced normal, reset, overload, fail-safe states.
// R9: Entering off/reset/overload/fail-safe reloads period 0100 and mode default; overload keeps the mode, fail-safe sets 001.
// R10: Overflow flag cleared in off and fail-safe; status fields per state.
// R11: Development option makes autonomous 001 the post-reset mode.
// R12: Development option with autonomous selection keeps watchdog off.
// R13: Host selects window or timeout in standby to test development option.
// R14: Window behaviour only with mode 100 in normal operation.
// R15: Window overflow or first-half trigger requests a system reset.
// R16: Window second-half trigger restarts the timer.
// R17: Timeout with 010 in normal/standby/sleep, and 100 in standby/sleep.
// R18: Timeout trigger restarts; overflow sets flag, or resets if pending.
// R19: Sleep timeout overflow produces a wake-up event.
// R20: Autonomous without option: timeout in normal, standby only if irq low.
// R21: Every valid control write triggers except a mode change in normal; new values act at once.
// R22: Mode codes 001/010/100; invalid codes abandon write, SPI failure irq.
// R23: Period code selects 8 to 4096 ms; default 0100 is 128 ms.
// R24: Mode change attempt in normal forces reset with cause 10000.
// R25: Window halves split at exactly half the selected period.
`ifndef WD_REGS_SVH
`define WD_REGS_SVH

`define WD_CTRL_ADDR      7'h00
`define WD_STAT_ADDR      7'h05
`define WD_CFG_ADDR       7'h74

`define WD_CFG_UV_MSB     5
`define WD_CFG_UV_LSB     4
`define WD_CFG_FNM_BIT    3
`define WD_CFG_DEV_BIT    2
`define WD_CFG_SLP_BIT    0
`define WD_CFG_RESET      8'h08

`define WD_MODE_AUTO      3'h1
`define WD_MODE_TIMEOUT   3'h2
`define WD_MODE_WINDOW    3'h4
`define WD_PER_8          4'h8
`define WD_PER_16         4'h1
`define WD_PER_32         4'h2
`define WD_PER_64         4'hb
`define WD_PER_128        4'h4
`define WD_PER_256        4'hd
`define WD_PER_1024       4'he
`define WD_PER_4096       4'h7
`define WD_PER_RESET      4'h4

`define WD_PHASE_OFF      2'h0
`define WD_PHASE_FIRST    2'h1
`define WD_PHASE_SECOND   2'h2
`define WD_CAUSE_ILLEGAL  5'h10

`define WD_MS_NS          1000000
`define WD_CLK_NS         50
`define WD_CYCLES_PER_MS  (`WD_MS_NS / `WD_CLK_NS)

`endif

// ### hw/wd_pkg.sv
// Purpose: Types and decode functions of the watchdog mode control block.
// Assumes: wd_regs.svh holds all numeric constants.
// Notes:   None.
`include "wd_regs.svh"

package wd_pkg;

	typedef enum logic [2:0] {
		ST_OFF, ST_FORCED_NORMAL, ST_STANDBY, ST_NORMAL,
		ST_SLEEP, ST_RESET, ST_OVERLOAD, ST_FAIL_SAFE
	} sbc_state_type;

	typedef enum logic [1:0] {
		WB_OFF, WB_TIMEOUT, WB_WINDOW
	} wd_behaviour_type;

	// Period in milliseconds; zero marks an invalid code.
	function automatic logic [12:0] period_ms(input logic [3:0] code);
		case (code)
			`WD_PER_8:    period_ms = 13'd8;
			`WD_PER_16:   period_ms = 13'd16;
			`WD_PER_32:   period_ms = 13'd32;
			`WD_PER_64:   period_ms = 13'd64;
			`WD_PER_128:  period_ms = 13'd128;
			`WD_PER_256:  period_ms = 13'd256;
			`WD_PER_1024: period_ms = 13'd1024;
			`WD_PER_4096: period_ms = 13'd4096;
			default:      period_ms = 13'd0;
		endcase
	endfunction

	function automatic logic mode_valid(input logic [2:0] code);
		mode_valid = (code == `WD_MODE_AUTO) || (code == `WD_MODE_TIMEOUT)
			|| (code == `WD_MODE_WINDOW);
	endfunction

endpackage

// ### hw/wd_timer_if.sv
// Purpose: Link between the mode controller and its period timer.
// Assumes: One clock domain.
// Notes:   None.
`timescale 1ns/1ns

interface wd_timer_if;
	logic        run;
	logic        restart;
	logic [12:0] period;
	logic        expired;
	logic        second_half;

	modport ctrl  (output run, output restart, output period,
		input expired, input second_half);
	modport timer (input run, input restart, input period,
		output expired, output second_half);
endinterface

// ### hw/wd_period_timer.sv
// Purpose: Millisecond prescaler and period counter of the watchdog.
// Assumes: period is a nonzero count of milliseconds while run is high.
// Notes:   expired is a one-cycle pulse; the counter wraps by itself.
`timescale 1ns/1ns
`include "wd_regs.svh"

module wd_period_timer #(
	parameter int CYCLES_PER_MS = `WD_CYCLES_PER_MS
) (
	input  wire logic   sys_clk_i,
	input  wire logic   arst_n_i,
	wd_timer_if.timer   tmr
);
	import wd_pkg::*;

	// The prescaler is 20 bits wide, which bounds the ratio from above.
	if (CYCLES_PER_MS < 2 || CYCLES_PER_MS > 1000000)
	begin : g_bad_cycles_per_ms
		$error("CYCLES_PER_MS out of range");
	end

	logic [19:0] presc_q, presc_d;
	logic [12:0] ms_q, ms_d;
	logic        tick;
	logic        last_ms;

	assign tick    = (presc_q == 20'(CYCLES_PER_MS - 1));
	assign last_ms = (ms_q == tmr.period - 13'd1);
	assign tmr.expired = tmr.run && !tmr.restart && tick && last_ms;
	assign tmr.second_half = tmr.run && (ms_q >= (tmr.period >> 1)); // R25

	always_comb
	begin
		presc_d = presc_q;
		ms_d    = ms_q;
		if (tmr.restart || !tmr.run)
		begin
			presc_d = 20'h0;
			ms_d    = 13'h0;
		end
		else if (tick)
		begin
			presc_d = 20'h0;
			ms_d    = last_ms ? 13'h0 : ms_q + 13'd1;
		end
		else
			presc_d = presc_q + 20'd1;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			presc_q <= 20'h0;
			ms_q    <= 13'h0;
		end
		else
		begin
			presc_q <= presc_d;
			ms_q    <= ms_d;
		end
	end

endmodule // wd_period_timer

// ### hw/sbc_watchdog_mode_control.sv
// Purpose: Watchdog mode selection, trigger checking and status of the
//          system basis chip.
// Assumes: Register port and chip state come from logic on sys_clk_i.
// Notes:   Reset pulse sequencing and the reset counter live elsewhere.
`timescale 1ns/1ns
`include "wd_regs.svh"

module sbc_watchdog_mode_control #(
	parameter int CYCLES_PER_MS = `WD_CYCLES_PER_MS
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  arst_n_i,
	input  wire wd_pkg::sbc_state_type sbc_state_i,
	input  wire logic                  host_irq_out_n_i,
	input  wire logic                  wr_en_i,
	input  wire logic [6:0]            addr_i,
	input  wire logic [7:0]            wdata_i,
	output      logic [7:0]            rdata_o,
	input  wire logic                  wd_irq_clear_i,
	input  wire logic                  spi_fail_irq_enable_i,
	output      logic                  wd_overflow_irq_o,
	output      logic                  spi_fail_irq_o,
	output      logic                  sys_reset_req_o,
	output      logic [4:0]            reset_cause_code_o,
	output      logic                  reset_cause_valid_o,
	output      logic                  wake_event_o,
	output      logic [1:0]            runtime_uv_threshold_sel_o,
	output      logic                  forced_normal_enable_o,
	output      logic                  sleep_disallow_o,
	output      logic [1:0]            wd_phase_state_o
);
	import wd_pkg::*;

	// ---------------------------------------------------------------
	// State and timer
	// ---------------------------------------------------------------
	logic [2:0]        wd_mode_select_q, wd_mode_select_d;
	logic [3:0]        wd_period_select_q, wd_period_select_d;
	logic [7:0]        cfg_q, cfg_d;
	logic              wdi_q, wdi_d;
	logic [1:0]        uv_rt_q, uv_rt_d;
	sbc_state_type     prev_state_q;
	logic [7:0]        rdata_q, rdata_d;
	logic              rst_req_q, rst_req_d;
	logic              wake_q, wake_d;
	logic              spi_fail_q, spi_fail_d;
	logic [4:0]        cause_q, cause_d;
	logic              cause_vld_q, cause_vld_d;
	wd_behaviour_type  beh_q;
	wd_behaviour_type  beh;
	logic              dev_option_enable;
	logic              entering;
	logic              ctrl_wr;
	logic              wr_legal;
	logic              trigger;
	logic [1:0]        phase;

	wd_timer_if tif ();

	wd_period_timer #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_timer (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.tmr       (tif.timer)
	);

	assign dev_option_enable = cfg_q[`WD_CFG_DEV_BIT];            // R3
	assign entering = (sbc_state_i != prev_state_q);

	// ---------------------------------------------------------------
	// Effective watchdog behaviour
	// ---------------------------------------------------------------
	always_comb
	begin
		beh = WB_OFF;                                            // R8
		case (sbc_state_i)
			ST_NORMAL:
				case (wd_mode_select_q)
					`WD_MODE_WINDOW:  beh = WB_WINDOW;          // R14
					`WD_MODE_TIMEOUT: beh = WB_TIMEOUT;         // R17
					`WD_MODE_AUTO:                              // R20
						beh = dev_option_enable ? WB_OFF : WB_TIMEOUT; // R12
					default:          beh = WB_OFF;
				endcase
			ST_STANDBY:
				case (wd_mode_select_q)
					`WD_MODE_WINDOW,
					`WD_MODE_TIMEOUT: beh = WB_TIMEOUT;         // R17
					`WD_MODE_AUTO:                              // R20
						beh = (!dev_option_enable && !host_irq_out_n_i)
							? WB_TIMEOUT : WB_OFF;              // R12
					default:          beh = WB_OFF;
				endcase
			ST_SLEEP:
				case (wd_mode_select_q)
					`WD_MODE_WINDOW,
					`WD_MODE_TIMEOUT: beh = WB_TIMEOUT;         // R17
					default:          beh = WB_OFF;             // R20
				endcase
			default: beh = WB_OFF;                              // R2
		endcase
	end

	// ---------------------------------------------------------------
	// Register writes and watchdog events
	// ---------------------------------------------------------------
	// Invalid codes are refused as a whole, so one flipped bit can never
	// leave half a configuration behind.
	assign ctrl_wr  = wr_en_i && (addr_i == `WD_CTRL_ADDR);
	assign wr_legal = mode_valid(wdata_i[7:5])
		&& (period_ms(wdata_i[3:0]) != 13'd0);                  // R22
	assign trigger  = ctrl_wr && wr_legal && !(sbc_state_i == ST_NORMAL
		&& wdata_i[7:5] != wd_mode_select_q);                  // R21

	always_comb
	begin
		wd_mode_select_d   = wd_mode_select_q;
		wd_period_select_d = wd_period_select_q;
		cfg_d              = cfg_q;
		wdi_d              = wdi_q;
		uv_rt_d            = uv_rt_q;
		rst_req_d          = 1'b0;
		wake_d             = 1'b0;
		spi_fail_d         = 1'b0;
		cause_d            = cause_q;
		cause_vld_d        = 1'b0;

		if (wr_en_i && addr_i == `WD_CFG_ADDR)
			cfg_d = wdata_i;

		if (wd_irq_clear_i)
			wdi_d = 1'b0;

		if (ctrl_wr)
		begin
			if (!wr_legal)
				spi_fail_d = spi_fail_irq_enable_i;             // R22
			else if (!trigger)
			begin
				rst_req_d   = 1'b1;                             // R24
				cause_d     = `WD_CAUSE_ILLEGAL;
				cause_vld_d = 1'b1;
			end
			else
			begin
				wd_mode_select_d   = wdata_i[7:5];              // R21
				wd_period_select_d = wdata_i[3:0];
				if (beh == WB_WINDOW && !tif.second_half)
					rst_req_d = 1'b1;                           // R15
			end
		end

		if (tif.expired)
		begin
			if (beh == WB_WINDOW)
				rst_req_d = 1'b1;                               // R15
			else if (beh == WB_TIMEOUT)
			begin
				if (wdi_q)
					rst_req_d = 1'b1;                           // R18
				wdi_d = 1'b1;                                   // R18
				if (sbc_state_i == ST_SLEEP)
					wake_d = 1'b1;                              // R19
			end
		end

		if (entering)
		begin
			case (sbc_state_i)
				ST_OFF, ST_RESET:
				begin
					wd_period_select_d = `WD_PER_RESET;         // R9
					wd_mode_select_d = dev_option_enable
						? `WD_MODE_AUTO : `WD_MODE_TIMEOUT;     // R11
				end
				ST_OVERLOAD:
					wd_period_select_d = `WD_PER_RESET;         // R9
				ST_FAIL_SAFE:
				begin
					wd_period_select_d = `WD_PER_RESET;         // R9
					wd_mode_select_d   = `WD_MODE_AUTO;
				end
				default: ;
			endcase
			if (sbc_state_i == ST_OFF)
				uv_rt_d = cfg_q[`WD_CFG_UV_MSB:`WD_CFG_UV_LSB]; // R1
		end

		if (sbc_state_i == ST_OFF || sbc_state_i == ST_FAIL_SAFE)
			wdi_d = 1'b0;                                       // R10
	end

	assign tif.run    = (beh != WB_OFF);
	// A change of behaviour restarts the count, so a new mode never
	// inherits a half-spent period.
	assign tif.restart = (beh != beh_q) || trigger;             // R16
	assign tif.period = period_ms(wd_period_select_q);          // R23

	// ---------------------------------------------------------------
	// Status and read data
	// ---------------------------------------------------------------
	always_comb
	begin
		if (beh == WB_OFF)
			phase = `WD_PHASE_OFF;                              // R7
		else if (tif.second_half)
			phase = `WD_PHASE_SECOND;
		else
			phase = `WD_PHASE_FIRST;
	end

	always_comb
	begin
		case (addr_i)
			`WD_CTRL_ADDR: rdata_d = {wd_mode_select_q, 1'b0,
				wd_period_select_q};
			`WD_STAT_ADDR: rdata_d = {4'h0,                     // R5
				sbc_state_i == ST_FORCED_NORMAL,                // R10
				dev_option_enable, phase};                      // R6
			`WD_CFG_ADDR:  rdata_d = cfg_q;
			default:       rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wd_mode_select_q   <= `WD_MODE_TIMEOUT;
			wd_period_select_q <= `WD_PER_RESET;
			cfg_q              <= `WD_CFG_RESET;
			wdi_q              <= 1'b0;
			uv_rt_q            <= 2'h0;
			prev_state_q       <= ST_OFF;
			rdata_q            <= 8'h00;
			rst_req_q          <= 1'b0;
			wake_q             <= 1'b0;
			spi_fail_q         <= 1'b0;
			cause_q            <= 5'h00;
			cause_vld_q        <= 1'b0;
			beh_q              <= WB_OFF;
		end
		else
		begin
			wd_mode_select_q   <= wd_mode_select_d;
			wd_period_select_q <= wd_period_select_d;
			cfg_q              <= cfg_d;
			wdi_q              <= wdi_d;
			uv_rt_q            <= uv_rt_d;
			prev_state_q       <= sbc_state_i;
			rdata_q            <= rdata_d;
			rst_req_q          <= rst_req_d;
			wake_q             <= wake_d;
			spi_fail_q         <= spi_fail_d;
			cause_q            <= cause_d;
			cause_vld_q        <= cause_vld_d;
			beh_q              <= beh;
		end
	end

	assign rdata_o                    = rdata_q;
	assign wd_overflow_irq_o          = wdi_q;
	assign spi_fail_irq_o             = spi_fail_q;
	assign sys_reset_req_o            = rst_req_q;
	assign reset_cause_code_o         = cause_q;
	assign reset_cause_valid_o        = cause_vld_q;
	assign wake_event_o               = wake_q;
	assign runtime_uv_threshold_sel_o = uv_rt_q;
	assign forced_normal_enable_o     = cfg_q[`WD_CFG_FNM_BIT];  // R2
	assign sleep_disallow_o           = cfg_q[`WD_CFG_SLP_BIT];  // R4
	assign wd_phase_state_o           = phase;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_off_states_idle: assert property (@(posedge sys_clk_i) // R8
		disable iff (!arst_n_i)
		(sbc_state_i inside {ST_OFF, ST_FORCED_NORMAL, ST_RESET,
			ST_OVERLOAD, ST_FAIL_SAFE}) |-> (phase == `WD_PHASE_OFF))
		else $error("watchdog active in a held-off state");

	a_dev_auto_off: assert property (@(posedge sys_clk_i) // R12
		disable iff (!arst_n_i)
		(dev_option_enable && wd_mode_select_q == `WD_MODE_AUTO)
			|-> !tif.run)
		else $error("autonomous watchdog runs with development option");

	a_window_early_reset: assert property (@(posedge sys_clk_i) // R15
		disable iff (!arst_n_i)
		(trigger && beh == WB_WINDOW && !tif.second_half)
			|=> sys_reset_req_o)
		else $error("early window trigger did not reset");

	a_timeout_no_reset: assert property (@(posedge sys_clk_i) // R18
		disable iff (!arst_n_i)
		(beh == WB_TIMEOUT && tif.expired && !wdi_q && !ctrl_wr
			&& !entering) |=> (wdi_q && !sys_reset_req_o))
		else $error("first timeout overflow mishandled");

	a_timeout_pending_rst: assert property (@(posedge sys_clk_i) // R18
		disable iff (!arst_n_i)
		(beh == WB_TIMEOUT && tif.expired && wdi_q) |=> sys_reset_req_o)
		else $error("pending overflow did not reset");

	a_sleep_wake: assert property (@(posedge sys_clk_i) // R19
		disable iff (!arst_n_i)
		(sbc_state_i == ST_SLEEP && beh == WB_TIMEOUT && tif.expired)
			|=> wake_event_o)
		else $error("sleep overflow gave no wake-up");

	a_illegal_mode_change: assert property (@(posedge sys_clk_i) // R24
		disable iff (!arst_n_i)
		(ctrl_wr && wr_legal && sbc_state_i == ST_NORMAL
			&& wdata_i[7:5] != wd_mode_select_q)
		|=> (sys_reset_req_o && reset_cause_code_o == `WD_CAUSE_ILLEGAL
			&& $stable(wd_mode_select_q)))
		else $error("mode change in normal not punished");

	a_invalid_code_kept: assert property (@(posedge sys_clk_i) // R22
		disable iff (!arst_n_i)
		(ctrl_wr && !wr_legal && !entering)
		|=> ($stable(wd_mode_select_q) && $stable(wd_period_select_q)
			&& spi_fail_irq_o == $past(spi_fail_irq_enable_i)))
		else $error("invalid control code was accepted");

	a_reset_entry_reload: assert property (@(posedge sys_clk_i) // R9
		disable iff (!arst_n_i)
		(entering && sbc_state_i == ST_RESET) |=>
		(wd_period_select_q == `WD_PER_RESET && wd_mode_select_q ==
			($past(dev_option_enable) ? `WD_MODE_AUTO : `WD_MODE_TIMEOUT)))
		else $error("reset entry did not reload watchdog");

	a_wdi_cleared: assert property (@(posedge sys_clk_i) // R10
		disable iff (!arst_n_i)
		(sbc_state_i == ST_FAIL_SAFE) |=> !wd_overflow_irq_o)
		else $error("overflow flag not cleared in fail-safe");

endmodule // sbc_watchdog_mode_control

// ### sim/host_model.sv
// Purpose: Host side model that writes and reads the register port.
// Assumes: Every call starts just after a rising edge of sys_clk_i.
// Notes:   Idle write data shows the inverse of the last byte sent.
`timescale 1ns/1ns
`include "wd_regs.svh"

module host_model (
	input  wire logic       sys_clk_i,
	output      logic       wr_en_o,
	output      logic [6:0] addr_o,
	output      logic [7:0] wdata_o
);
	initial
	begin
		wr_en_o = 1'b0;
		addr_o = `WD_STAT_ADDR;
		wdata_o = 8'h00;
	end

	// Stale data is inverted so a design that samples late sees garbage.
	task automatic write(input logic [6:0] a, input logic [7:0] d);
		wr_en_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(posedge sys_clk_i);
		#1;
		wr_en_o = 1'b0;
		wdata_o = ~d;
	endtask

	task automatic read(input logic [6:0] a);
		addr_o = a;
		@(posedge sys_clk_i);
		#1;
	endtask
endmodule // host_model

// ### sim/tb.sv
// Purpose: Self-checking bench of the watchdog mode control block.
// Assumes: One millisecond is shortened to four clock cycles.
// Notes:   Drivers queue expectations; a monitor compares them.
`timescale 1ns/1ns
`include "wd_regs.svh"

module tb;
	import wd_pkg::*;

	typedef struct {
		int         sel;
		logic [7:0] val;
	} note_type;

	logic          sys_clk;
	logic          arst_n;
	sbc_state_type sbc_state;
	logic          host_irq_n;
	logic          irq_clear;
	logic          spi_fail_en;
	logic          wr_en;
	logic [6:0]    addr;
	logic [7:0]    wdata;
	logic [7:0]    rdata;
	logic          ovf_irq, spi_irq, rst_req, cause_vld, wake;
	logic [4:0]    cause;
	logic [1:0]    uv;
	logic          fn_en;
	logic          slp_dis;
	logic [1:0]    phase;
	note_type      q[$];
	int            fail_count = 0;
	int            comparisons = 0;
	event          noted;

	sbc_watchdog_mode_control #(.CYCLES_PER_MS(4)) dut (
		.sys_clk_i(sys_clk), .arst_n_i(arst_n),
		.sbc_state_i(sbc_state), .host_irq_out_n_i(host_irq_n),
		.wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata),
		.rdata_o(rdata), .wd_irq_clear_i(irq_clear),
		.spi_fail_irq_enable_i(spi_fail_en),
		.wd_overflow_irq_o(ovf_irq), .spi_fail_irq_o(spi_irq),
		.sys_reset_req_o(rst_req), .reset_cause_code_o(cause),
		.reset_cause_valid_o(cause_vld), .wake_event_o(wake),
		.runtime_uv_threshold_sel_o(uv),
		.forced_normal_enable_o(fn_en),
		.sleep_disallow_o(slp_dis), .wd_phase_state_o(phase));

	host_model host (.sys_clk_i(sys_clk), .wr_en_o(wr_en),
		.addr_o(addr), .wdata_o(wdata));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] obs(input int s);
		case (s)
			0: obs = rdata;
			1: obs = {3'h0, ovf_irq, spi_irq, rst_req, cause_vld, wake};
			2: obs = {2'h0, uv, fn_en, slp_dis, phase};
			default: obs = {3'h0, cause};
		endcase
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic note(input int s, input logic [7:0] v);
		q.push_back('{s, v});
		-> noted;
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] v);
		host.read(a);
		note(0, v);
	endtask

	task automatic stat(input logic [7:0] v);
		rd(`WD_STAT_ADDR, v);
	endtask

	task automatic ctl(input logic [7:0] d);
		host.write(`WD_CTRL_ADDR, d);
	endtask

	task automatic go(input sbc_state_type s);
		sbc_state = s;
		cyc(1);
	endtask

	// Pulses stand one cycle, so the wait stops in the cycle they show.
	task automatic wait_bit(input int b, input int lim, input logic [7:0] v);
		int n;
		logic [7:0] o;
		for (n = 0; n < lim; n++)
		begin
			o = obs(1);
			if (o[b] === 1'b1)
				break;
			cyc(1);
		end
		note(1, v);
	endtask

	task automatic done(input int n);
		$display("test %0d finished", n);
	endtask

	task automatic stop_test();
		#1;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Clock, monitor and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial
	begin
		note_type n;
		forever
		begin
			@(noted);
			while (q.size() > 0)
			begin
				n = q.pop_front();
				comparisons++;
				if (obs(n.sel) !== n.val)
				begin
					fail_count++;
					$display("Error at %0t: view %0d got %h want %h",
						$time, n.sel, obs(n.sel), n.val);
				end
			end
		end
	end

	initial
	begin
		#1000000;
		fail_count++;
		$display("Error at %0t: run did not finish", $time);
		stop_test();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial
	begin
		logic [7:0]    c;
		int            k;
		logic [7:0]    bad [4];
		sbc_state_type tail [4];
		bad = '{8'h68, 8'h49, 8'he8, 8'h0f};
		tail = '{ST_RESET, ST_OVERLOAD, ST_FORCED_NORMAL, ST_FAIL_SAFE};
		arst_n = 1'b0;
		sbc_state = ST_STANDBY;
		host_irq_n = 1'b1;
		irq_clear = 1'b0;
		spi_fail_en = 1'b1;
		void'($urandom(22));
		cyc(2);
		arst_n = 1'b1;
		stat(8'h01);
		rd(`WD_CTRL_ADDR, 8'h44);
		rd(`WD_CFG_ADDR, 8'h08);
		note(2, 8'h09);
		done(1);
		for (k = 0; k < 4; k++)
		begin
			c = {2'h0, k[1:0], 4'($urandom) & 4'hd};
			host.write(`WD_CFG_ADDR, c);
			rd(`WD_CFG_ADDR, c);
			go(ST_OFF);
			note(2, {2'h0, c[5:4], c[3], c[0], 2'h0});
			rd(`WD_CTRL_ADDR, {c[2] ? 3'h1 : 3'h2, 5'h04});
			go(ST_FORCED_NORMAL);
			stat({4'h0, 1'b1, c[2], 2'h0});
			go(ST_STANDBY);
			stat({5'h0, c[2], 1'b0, !c[2]});
		end
		host.write(`WD_CFG_ADDR, 8'h00);
		done(2);
		foreach (bad[i])
		begin
			ctl(8'h48);
			cyc(1);
			ctl(bad[i]);
			note(1, 8'h08);
			rd(`WD_CTRL_ADDR, 8'h48);
		end
		spi_fail_en = 1'b0;
		ctl(8'h68);
		note(1, 8'h00);
		spi_fail_en = 1'b1;
		cyc(1);
		host.write(7'h10, 8'h84);
		rd(`WD_CTRL_ADDR, 8'h48);
		done(3);
		go(ST_NORMAL);
		ctl(8'h48);
		repeat (3)
		begin
			cyc(24);
			ctl(8'h48);
		end
		note(1, 8'h00);
		cyc(6);
		stat(8'h01);
		cyc(12);
		stat(8'h02);
		cyc(6);
		note(1, 8'h00);
		wait_bit(4, 12, 8'h10);
		wait_bit(2, 40, 8'h14);
		irq_clear = 1'b1;
		cyc(1);
		irq_clear = 1'b0;
		note(1, 8'h00);
		done(4);
		go(ST_SLEEP);
		wait_bit(0, 40, 8'h11);
		done(5);
		go(ST_STANDBY);
		ctl(8'h88);
		stat(8'h01);
		go(ST_NORMAL);
		cyc(3);
		ctl(8'h88);
		note(1, 8'h14);
		go(ST_STANDBY);
		go(ST_NORMAL);
		cyc(20);
		ctl(8'h88);
		note(1, 8'h10);
		cyc(26);
		note(1, 8'h10);
		wait_bit(2, 12, 8'h14);
		ctl(8'h48);
		note(1, 8'h16);
		note(3, 8'h10);
		rd(`WD_CTRL_ADDR, 8'h88);
		done(6);
		go(ST_STANDBY);
		ctl(8'h28);
		stat(8'h00);
		host_irq_n = 1'b0;
		cyc(1);
		stat(8'h01);
		go(ST_NORMAL);
		host_irq_n = 1'b1;
		cyc(1);
		stat(8'h01);
		foreach (tail[i])
		begin
			go(tail[i]);
			stat({4'h0, tail[i] == ST_FORCED_NORMAL, 3'h0});
		end
		note(1, 8'h00);
		rd(`WD_CTRL_ADDR, 8'h24);
		host.write(`WD_CFG_ADDR, 8'h04);
		go(ST_NORMAL);
		stat(8'h04);
		done(7);
		stop_test();
	end
endmodule // tb
